// >>> logic/ars_pkg.sv
package ars_pkg;

   // Register byte offsets on the APB slave.
   localparam logic [7:0] AMP_CTRL_OFS = 8'h00;   // Amplifier and reference control.
   localparam logic [7:0] BG_CTRL_OFS  = 8'h04;   // Bandgap enable control.
   localparam logic [7:0] INSEL_OFS    = 8'h08;   // Input signal and channel select.
   localparam logic [7:0] PIN_AN_OFS   = 8'h0C;   // Pin function: analog input per pin.
   localparam logic [7:0] PIN_PU_OFS   = 8'h10;   // Programmed pull-high per pin.
   localparam logic [7:0] PIN_DIR_OFS  = 8'h14;   // Port direction, one means output.
   localparam logic [7:0] STATUS_OFS   = 8'h18;   // Read-only routing status.

   // Field positions in the amplifier control register.
   localparam int AMP_EN_BIT  = 7;
   localparam int AMP_SRC_BIT = 4;
   localparam int REF_SEL_LSB = 2;
   localparam int GAIN_LSB    = 0;

   // Field positions in the bandgap and input select registers.
   localparam int BG_EN_BIT   = 0;
   localparam int INSEL_LSB   = 4;
   localparam int CHSEL_LSB   = 0;

   // Reset values and writable masks.
   localparam logic [7:0]  AMP_CTRL_RST  = 8'h00;
   localparam logic [7:0]  AMP_CTRL_MASK = 8'h9F;
   localparam logic [7:0]  BG_CTRL_RST   = 8'h00;
   localparam logic [7:0]  BG_CTRL_MASK  = 8'h01;
   localparam logic [7:0]  INSEL_RST     = 8'h00;
   localparam logic [15:0] PIN_RST       = 16'h0000;
   localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

   // Reference select codes; any code with the top bit set picks the amplifier.
   localparam logic [1:0] REF_SUPPLY = 2'h0;
   localparam logic [1:0] REF_PIN    = 2'h1;

   // Channel select code that names no pin inside the implemented range.
   localparam logic [3:0] CH_RESERVED = 4'h2;

   // One-hot positions of the internal signal bus.
   localparam int INT_SUPPLY  = 0;
   localparam int INT_SUP_2   = 1;
   localparam int INT_SUP_4   = 2;
   localparam int INT_AMP     = 3;
   localparam int INT_AMP_2   = 4;
   localparam int INT_AMP_4   = 5;
   localparam int INT_GROUND  = 6;
   localparam int INT_W       = 7;

endpackage

// >>> logic/ars_sel_if.sv
`timescale 1ns/1ps
// Carries the converter input selection to the decoder and its result back.
interface ars_sel_if #(parameter int NCH = 9);
   logic [3:0]     input_signal_select;   // Input signal select field.
   logic [3:0]     channel_select;        // External channel select field.
   logic [NCH-1:0] ext_conn;              // One-hot external channel switch.
   logic [6:0]     int_sel;               // One-hot internal signal switch.

   modport ctrl (output input_signal_select, output channel_select,
                 input ext_conn, input int_sel);
   modport dec  (input input_signal_select, input channel_select,
                 output ext_conn, output int_sel);
endinterface

// >>> logic/ars_input_decode.sv
`timescale 1ns/1ps
// Turns the input signal and channel select fields into analog switch enables.
module ars_input_decode
   import ars_pkg::*;
(
   ars_sel_if.dec sel
);

   localparam int NCH = $bits(sel.ext_conn);

   // Decode is purely combinational; the owner registers the result.
   always_comb
   begin
      logic ext_mode;
      ext_mode     = 1'b0;
      sel.int_sel  = '0;
      sel.ext_conn = '0;
      // External path for 0000, 0100 and 11xx; all else is internal.
      ext_mode = (sel.input_signal_select == 4'h0) || (sel.input_signal_select == 4'h4)
                 || (sel.input_signal_select[3:2] == 2'b11);
      case (sel.input_signal_select)
         4'h1:    sel.int_sel[INT_SUPPLY] = 1'b1;
         4'h2:    sel.int_sel[INT_SUP_2]  = 1'b1;
         4'h3:    sel.int_sel[INT_SUP_4]  = 1'b1;
         4'h5:    sel.int_sel[INT_AMP]    = 1'b1;
         4'h6:    sel.int_sel[INT_AMP_2]  = 1'b1;
         4'h7:    sel.int_sel[INT_AMP_4]  = 1'b1;
         4'h8, 4'h9, 4'hA, 4'hB:
                  sel.int_sel[INT_GROUND] = 1'b1;
         default: sel.int_sel = '0;
      endcase
      // Internal selection keeps every pin switch open, whatever the channel.
      if (ext_mode)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            // Reserved and out-of-range codes leave the input floating.
            if ((4'(i) == sel.channel_select) && (sel.channel_select != CH_RESERVED))
            begin
               sel.ext_conn[i] = 1'b1;
            end
         end
      end
   end

endmodule

// >>> logic/ars_top.sv
`timescale 1ns/1ps
module ars_top
   import ars_pkg::*;
#(
   parameter int NPIN = 11,   // Nine channel pins plus the two reference pins.
   parameter int NCH  = 9     // Implemented external channel switches.
)
(
   input  logic            pclk,
   input  logic            presetn,
   input  logic            psel,
   input  logic            penable,
   input  logic            pwrite,
   input  logic [7:0]      paddr,
   input  logic [31:0]     pwdata,
   input  logic [3:0]      pstrb,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   output logic            amp_enable,
   output logic            amp_ref_pin_connect,
   output logic            bandgap_voltage_to_amp,
   output logic [1:0]      amp_gain_select,
   output logic            ref_from_supply,
   output logic            ref_pin_connect,
   output logic            ref_from_amp_output,
   output logic            bandgap_enable,
   output logic [NCH-1:0]  ext_channel_connect,
   output logic [6:0]      internal_signal_sel,
   output logic [NPIN-1:0] pin_analog_en,
   output logic [NPIN-1:0] pin_digital_en,
   output logic [NPIN-1:0] pin_pullup_en,
   output logic [NPIN-1:0] pin_drive_en
);

   // Software-visible storage.
   logic [7:0]      amp_ctrl_reg;    // Amplifier and reference control.
   logic [7:0]      amp_ctrl_next;
   logic [7:0]      bg_ctrl_reg;     // Bandgap control.
   logic [7:0]      bg_ctrl_next;
   logic [7:0]      insel_reg;       // Input signal and channel select.
   logic [7:0]      insel_next;
   logic [NPIN-1:0] pin_an_reg;      // Analog function per pin.
   logic [NPIN-1:0] pin_an_next;
   logic [NPIN-1:0] pin_pu_reg;      // Programmed pull-high per pin.
   logic [NPIN-1:0] pin_pu_next;
   logic [NPIN-1:0] pin_dir_reg;     // Port direction, one drives the pin.
   logic [NPIN-1:0] pin_dir_next;
   logic [31:0]     prdata_reg;      // Read data, loaded in the setup phase.
   logic [31:0]     prdata_next;

   // Registered analog control outputs.
   logic            amp_en_reg;
   logic            amp_en_next;
   logic            amp_pin_reg;
   logic            amp_pin_next;
   logic            amp_bg_reg;
   logic            amp_bg_next;
   logic [1:0]      gain_reg;
   logic [1:0]      gain_next;
   logic            ref_sup_reg;
   logic            ref_sup_next;
   logic            ref_pin_reg;
   logic            ref_pin_next;
   logic            ref_amp_reg;
   logic            ref_amp_next;
   logic            bg_en_reg;
   logic            bg_en_next;
   logic [NCH-1:0]  ext_reg;
   logic [NCH-1:0]  ext_next;
   logic [6:0]      int_reg;
   logic [6:0]      int_next;
   logic [NPIN-1:0] an_out_reg;
   logic [NPIN-1:0] an_out_next;
   logic [NPIN-1:0] pu_out_reg;
   logic [NPIN-1:0] pu_out_next;
   logic [NPIN-1:0] drv_out_reg;
   logic [NPIN-1:0] drv_out_next;

   // Bus decode helpers.
   logic            setup_ph;        // First cycle of a transfer.
   logic            access_wr;       // Completing write, pready is always high.
   logic            addr_hit;        // Address names a register.
   logic [31:0]     byte_mask;       // Byte lanes enabled by pstrb.

   // Link to the input decoder.
   ars_sel_if #(.NCH(NCH)) sel ();

   ars_input_decode u_dec (
      .sel (sel)
   );

   assign sel.input_signal_select = insel_reg[INSEL_LSB +: 4];
   assign sel.channel_select      = insel_reg[CHSEL_LSB +: 4];

   // The slave never inserts wait states, so every access is one setup and one access cycle.
   assign setup_ph  = psel && !penable;
   assign access_wr = psel && penable && pwrite;
   assign addr_hit  = (paddr == AMP_CTRL_OFS) || (paddr == BG_CTRL_OFS)
                      || (paddr == INSEL_OFS) || (paddr == PIN_AN_OFS)
                      || (paddr == PIN_PU_OFS) || (paddr == PIN_DIR_OFS)
                      || (paddr == STATUS_OFS);
   assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addr_hit;
   assign prdata    = prdata_reg;

   // Register writes land at the access edge; unused bits are never stored.
   always_comb
   begin
      logic [31:0] wd;
      wd            = pwdata & byte_mask;
      amp_ctrl_next = amp_ctrl_reg;
      bg_ctrl_next  = bg_ctrl_reg;
      insel_next    = insel_reg;
      pin_an_next   = pin_an_reg;
      pin_pu_next   = pin_pu_reg;
      pin_dir_next  = pin_dir_reg;
      if (access_wr)
      begin
         case (paddr)
            AMP_CTRL_OFS:
               amp_ctrl_next = ((wd[7:0] | (amp_ctrl_reg & ~byte_mask[7:0]))) & AMP_CTRL_MASK;
            BG_CTRL_OFS:
               bg_ctrl_next  = ((wd[7:0] | (bg_ctrl_reg & ~byte_mask[7:0]))) & BG_CTRL_MASK;
            INSEL_OFS:
               insel_next    = wd[7:0] | (insel_reg & ~byte_mask[7:0]);
            PIN_AN_OFS:
               pin_an_next   = wd[NPIN-1:0] | (pin_an_reg & ~byte_mask[NPIN-1:0]);
            PIN_PU_OFS:
               pin_pu_next   = wd[NPIN-1:0] | (pin_pu_reg & ~byte_mask[NPIN-1:0]);
            PIN_DIR_OFS:
               pin_dir_next  = wd[NPIN-1:0] | (pin_dir_reg & ~byte_mask[NPIN-1:0]);
            default:
               amp_ctrl_next = amp_ctrl_reg;
         endcase
      end
   end

   // Read data is staged in the setup cycle so it is a flop output in the access cycle.
   always_comb
   begin
      prdata_next = prdata_reg;
      if (setup_ph && !pwrite)
      begin
         prdata_next = RDATA_RST;
         case (paddr)
            AMP_CTRL_OFS: prdata_next[7:0]      = amp_ctrl_reg;
            BG_CTRL_OFS:  prdata_next[7:0]      = bg_ctrl_reg;
            INSEL_OFS:    prdata_next[7:0]      = insel_reg;
            PIN_AN_OFS:   prdata_next[NPIN-1:0] = pin_an_reg;
            PIN_PU_OFS:   prdata_next[NPIN-1:0] = pin_pu_reg;
            PIN_DIR_OFS:  prdata_next[NPIN-1:0] = pin_dir_reg;
            STATUS_OFS:   prdata_next[NCH+6:0]  = {int_reg, ext_reg};
            default:      prdata_next           = RDATA_RST;
         endcase
      end
   end

   // Register group: storage and read data.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         amp_ctrl_reg <= AMP_CTRL_RST;
         bg_ctrl_reg  <= BG_CTRL_RST;
         insel_reg    <= INSEL_RST;
         pin_an_reg   <= PIN_RST[NPIN-1:0];
         pin_pu_reg   <= PIN_RST[NPIN-1:0];
         pin_dir_reg  <= PIN_RST[NPIN-1:0];
         prdata_reg   <= RDATA_RST;
      end
      else
      begin
         amp_ctrl_reg <= amp_ctrl_next;
         bg_ctrl_reg  <= bg_ctrl_next;
         insel_reg    <= insel_next;
         pin_an_reg   <= pin_an_next;
         pin_pu_reg   <= pin_pu_next;
         pin_dir_reg  <= pin_dir_next;
         prdata_reg   <= prdata_next;
      end
   end

   // Analog switch controls, registered so the pads see glitch-free levels.
   always_comb
   begin
      amp_en_next  = amp_ctrl_reg[AMP_EN_BIT];
      amp_bg_next  = amp_ctrl_reg[AMP_SRC_BIT];
      amp_pin_next = !amp_ctrl_reg[AMP_SRC_BIT];
      gain_next    = amp_ctrl_reg[GAIN_LSB +: 2];
      ref_sup_next = (amp_ctrl_reg[REF_SEL_LSB +: 2] == REF_SUPPLY);
      ref_pin_next = (amp_ctrl_reg[REF_SEL_LSB +: 2] == REF_PIN);
      ref_amp_next = amp_ctrl_reg[REF_SEL_LSB + 1];
      bg_en_next   = bg_ctrl_reg[BG_EN_BIT];
      ext_next     = sel.ext_conn;
      int_next     = sel.int_sel;
      an_out_next  = pin_an_reg;
      pu_out_next  = pin_pu_reg & ~pin_an_reg;
      // Analog use wins over the port direction, so no prior input setup is needed.
      drv_out_next = pin_dir_reg & ~pin_an_reg;
   end

   // Output group: one cycle behind the storage.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         amp_en_reg  <= 1'b0;
         amp_pin_reg <= 1'b1;
         amp_bg_reg  <= 1'b0;
         gain_reg    <= 2'h0;
         ref_sup_reg <= 1'b1;
         ref_pin_reg <= 1'b0;
         ref_amp_reg <= 1'b0;
         bg_en_reg   <= 1'b0;
         ext_reg     <= '0;
         int_reg     <= '0;
         an_out_reg  <= '0;
         pu_out_reg  <= '0;
         drv_out_reg <= '0;
      end
      else
      begin
         amp_en_reg  <= amp_en_next;
         amp_pin_reg <= amp_pin_next;
         amp_bg_reg  <= amp_bg_next;
         gain_reg    <= gain_next;
         ref_sup_reg <= ref_sup_next;
         ref_pin_reg <= ref_pin_next;
         ref_amp_reg <= ref_amp_next;
         bg_en_reg   <= bg_en_next;
         ext_reg     <= ext_next;
         int_reg     <= int_next;
         an_out_reg  <= an_out_next;
         pu_out_reg  <= pu_out_next;
         drv_out_reg <= drv_out_next;
      end
   end

   assign amp_enable             = amp_en_reg;
   assign amp_ref_pin_connect    = amp_pin_reg;
   assign bandgap_voltage_to_amp = amp_bg_reg;
   assign amp_gain_select        = gain_reg;
   assign ref_from_supply        = ref_sup_reg;
   assign ref_pin_connect        = ref_pin_reg;
   assign ref_from_amp_output    = ref_amp_reg;
   assign bandgap_enable         = bg_en_reg;
   assign ext_channel_connect    = ext_reg;
   assign internal_signal_sel    = int_reg;
   assign pin_analog_en          = an_out_reg;
   // Digital paths are cut on any analog pin.
   assign pin_digital_en         = ~an_out_reg;
   assign pin_pullup_en          = pu_out_reg;
   assign pin_drive_en           = drv_out_reg;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_amp_wr;
      access_wr && (paddr == AMP_CTRL_OFS) && pstrb[0];
   endsequence
   sequence s_insel_wr;
      access_wr && (paddr == INSEL_OFS) && pstrb[0];
   endsequence

   property p_amp_en;
      s_amp_wr |-> ##2 (amp_enable == $past(pwdata[AMP_EN_BIT], 2));
   endproperty
   a_amp_en: assert property (p_amp_en) else $error("amp enable wrong");

   property p_amp_rsvd;
      (setup_ph && !pwrite && (paddr == AMP_CTRL_OFS)) |=> (prdata[6:5] == 2'h0);
   endproperty
   a_amp_rsvd: assert property (p_amp_rsvd) else $error("reserved bits nonzero");

   property p_amp_src;
      (s_amp_wr ##0 pwdata[AMP_SRC_BIT]) |-> ##2 (bandgap_voltage_to_amp && !amp_ref_pin_connect);
   endproperty
   a_amp_src: assert property (p_amp_src) else $error("amp source path wrong");

   property p_ref_sel;
      s_amp_wr |-> ##2 ((ref_pin_connect == ($past(pwdata[3:2], 2) == REF_PIN))
                        && (ref_from_amp_output == $past(pwdata[3], 2)));
   endproperty
   a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong");

   property p_gain;
      s_amp_wr |-> ##2 (amp_gain_select == $past(pwdata[1:0], 2));
   endproperty
   a_gain: assert property (p_gain) else $error("gain select wrong");

   property p_bg;
      (access_wr && (paddr == BG_CTRL_OFS) && pstrb[0])
         |-> ##2 (bandgap_enable == $past(pwdata[BG_EN_BIT], 2)) ##1 (bg_ctrl_reg[7:1] == 7'h00);
   endproperty
   a_bg: assert property (p_bg) else $error("bandgap control wrong");

   property p_ext_route;
      (s_insel_wr ##0 (pwdata[7:4] == 4'hC) && (pwdata[3:0] == 4'h1))
         |-> ##2 (ext_channel_connect == NCH'(2));
   endproperty
   a_ext_route: assert property (p_ext_route) else $error("external route wrong");

   property p_int_excl;
      (internal_signal_sel != 7'h00) |-> (ext_channel_connect == '0);
   endproperty
   a_int_excl: assert property (p_int_excl) else $error("external left on");

   property p_int_amp;
      (s_insel_wr ##0 (pwdata[7:4] == 4'h6)) |-> ##2 (internal_signal_sel == 7'h10);
   endproperty
   a_int_amp: assert property (p_int_amp) else $error("internal decode wrong");

   property p_float;
      (s_insel_wr ##0 (pwdata[7:4] == 4'h0) && (pwdata[3:0] > 4'h8)) |-> ##2
         ((ext_channel_connect == '0) && (internal_signal_sel == 7'h00));
   endproperty
   a_float: assert property (p_float) else $error("floating code connected");

   property p_pin_ovr;
      ((pin_analog_en & (pin_pullup_en | pin_drive_en | pin_digital_en)) == '0);
   endproperty
   a_pin_ovr: assert property (p_pin_ovr) else $error("pin leak");

endmodule

// >>> verif/ars_analog_model.sv
`timescale 1ns/1ps
// Stands in for the analog switch matrix; it raises clash when two sources would meet.
module ars_analog_model
#(
   parameter int NCH  = 9,    // External channel switches.
   parameter int NPIN = 11    // Pins with a shared analog function.
)
(
   input  logic            amp_ref_pin_connect,
   input  logic            bandgap_voltage_to_amp,
   input  logic            ref_from_supply,
   input  logic            ref_pin_connect,
   input  logic            ref_from_amp_output,
   input  logic [NCH-1:0]  ext_channel_connect,
   input  logic [6:0]      internal_signal_sel,
   input  logic [NPIN-1:0] pin_analog_en,
   input  logic [NPIN-1:0] pin_pullup_en,
   input  logic [NPIN-1:0] pin_drive_en,
   output logic            clash
);
   // A shorted node would damage real silicon, so any overlap is flagged at once.
   always_comb
   begin
      clash = amp_ref_pin_connect & bandgap_voltage_to_amp;
      clash |= $countones({ref_from_supply, ref_pin_connect, ref_from_amp_output}) != 1;
      clash |= (|ext_channel_connect) & (|internal_signal_sel);
      clash |= ($countones(ext_channel_connect) > 1) | ($countones(internal_signal_sel) > 1);
      clash |= |(pin_analog_en & (pin_pullup_en | pin_drive_en));
   end
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
// Self-checking bench: drivers queue expectations, one monitor compares them.
module tb;
   import ars_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, obs, clash;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        pready, pslverr, amp_enable, amp_ref_pin_connect, bandgap_voltage_to_amp;
   logic        ref_from_supply, ref_pin_connect, ref_from_amp_output, bandgap_enable;
   logic [1:0]  amp_gain_select;
   logic [8:0]  ext_channel_connect;
   logic [6:0]  internal_signal_sel;
   logic [10:0] pin_analog_en, pin_digital_en, pin_pullup_en, pin_drive_en;
   logic [7:0]  amp_m, bg_m, ins_m;   // Software's view of the byte registers.
   logic [10:0] an_m, pu_m, dir_m;    // Software's view of the pin registers.
   logic [33:0] bus_q[$];             // Per transfer: {is read, error, data}.
   logic [68:0] out_q[$];             // Expected output snapshots.
   logic [33:0] be;
   logic [68:0] oe, seen;
   int          err_count, checks, seed;
   assign seen = {amp_enable, amp_ref_pin_connect, bandgap_voltage_to_amp, amp_gain_select,
                  ref_from_supply, ref_pin_connect, ref_from_amp_output, bandgap_enable,
                  internal_signal_sel, ext_channel_connect, pin_analog_en, pin_digital_en,
                  pin_pullup_en, pin_drive_en};
   ars_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .amp_enable(amp_enable),
      .amp_ref_pin_connect(amp_ref_pin_connect), .bandgap_voltage_to_amp(bandgap_voltage_to_amp),
      .amp_gain_select(amp_gain_select), .ref_from_supply(ref_from_supply),
      .ref_pin_connect(ref_pin_connect), .ref_from_amp_output(ref_from_amp_output),
      .bandgap_enable(bandgap_enable), .ext_channel_connect(ext_channel_connect),
      .internal_signal_sel(internal_signal_sel), .pin_analog_en(pin_analog_en),
      .pin_digital_en(pin_digital_en), .pin_pullup_en(pin_pullup_en), .pin_drive_en(pin_drive_en));
   ars_analog_model far (.amp_ref_pin_connect(amp_ref_pin_connect),
      .bandgap_voltage_to_amp(bandgap_voltage_to_amp), .ref_from_supply(ref_from_supply),
      .ref_pin_connect(ref_pin_connect), .ref_from_amp_output(ref_from_amp_output),
      .ext_channel_connect(ext_channel_connect), .internal_signal_sel(internal_signal_sel),
      .pin_analog_en(pin_analog_en), .pin_pullup_en(pin_pullup_en),
      .pin_drive_en(pin_drive_en), .clash(clash));
   // The clock toggles every half period of 2.5 ns.
   always #2.5 pclk = ~pclk;
   // Compares one value and counts the outcome.
   task automatic check(input logic [68:0] got, input logic [68:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Works out every analog control output from the software registers.
   function automatic logic [68:0] exp_out();
      logic [3:0] ins;
      logic [3:0] ch;
      logic [8:0] ext;
      logic [6:0] isel;
      ins = ins_m[7:4];
      ch = ins_m[3:0];
      ext = '0;
      isel = '0;
      if (ins == 4'h0 || ins == 4'h4 || ins >= 4'hc)
      begin
         if (ch <= 4'h8 && ch != 4'h2)
            ext[ch] = 1'b1;
      end
      else if (ins >= 4'h8)
         isel[6] = 1'b1;
      else
         isel[ins - (ins[2] ? 4'h2 : 4'h1)] = 1'b1;
      return {amp_m[7], !amp_m[4], amp_m[4], amp_m[1:0], amp_m[3:2] == 2'h0,
              amp_m[3:2] == 2'h1, amp_m[3], bg_m[0], isel, ext,
              an_m, ~an_m, pu_m & ~an_m, dir_m & ~an_m};
   endfunction
   // One APB transfer; the request is held until pready is seen high.
   task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic w);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      pwrite <= w;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         check(1'b0, 1'b1, "pready never came");
   endtask
   // Writes a register and updates the software view lane by lane.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      logic        bad;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      d = d & m;
      bad = 1'b0;
      case (a)
         AMP_CTRL_OFS: amp_m = ((amp_m & ~m[7:0]) | d[7:0]) & AMP_CTRL_MASK;
         BG_CTRL_OFS:  bg_m = ((bg_m & ~m[7:0]) | d[7:0]) & BG_CTRL_MASK;
         INSEL_OFS:    ins_m = (ins_m & ~m[7:0]) | d[7:0];
         PIN_AN_OFS:   an_m = (an_m & ~m[10:0]) | d[10:0];
         PIN_PU_OFS:   pu_m = (pu_m & ~m[10:0]) | d[10:0];
         PIN_DIR_OFS:  dir_m = (dir_m & ~m[10:0]) | d[10:0];
         default:      bad = 1'b1;
      endcase
      bus_q.push_back({1'b0, bad, 32'h0000_0000});
      bus(a, d, s, 1'b1);
   endtask
   // Reads a register; the expected word comes from the software view.
   task automatic rd(input logic [7:0] a);
      logic [68:0] o;
      logic [31:0] e;
      o = exp_out();
      case (a)
         AMP_CTRL_OFS: e = {24'h00_0000, amp_m};
         BG_CTRL_OFS:  e = {24'h00_0000, bg_m};
         INSEL_OFS:    e = {24'h00_0000, ins_m};
         PIN_AN_OFS:   e = {21'h00_0000, an_m};
         PIN_PU_OFS:   e = {21'h00_0000, pu_m};
         PIN_DIR_OFS:  e = {21'h00_0000, dir_m};
         STATUS_OFS:   e = {16'h0000, o[59:44]};
         default:      e = 32'h0000_0000;
      endcase
      bus_q.push_back({1'b1, a > STATUS_OFS || a[1:0] != 2'h0, e});
      bus(a, 32'h0000_0000, 4'hf, 1'b0);
   endtask
   // Frees the bus and samples the outputs one cycle after the last write settled.
   task automatic check_out();
      out_q.push_back(exp_out());
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      obs <= 1'b1;
      @(posedge pclk);
      obs <= 1'b0;
   endtask
   // Monitor: each finished transfer and each sample request takes its oldest note.
   always @(posedge pclk)
   begin
      if (psel && penable && pready)
      begin
         be = bus_q.pop_front();
         check(pslverr, be[32], "slave error");
         if (be[33])
            check(prdata, be[31:0], "read data");
      end
      if (obs)
      begin
         oe = out_q.pop_front();
         check(seen[68:60], oe[68:60], "amp");
         check(seen[59:44], oe[59:44], "routing");
         check(seen[43:0], oe[43:0], "pin controls");
         check(clash, 1'b0, "sources shorted");
      end
   end
   // Cuts a hang short well beyond the few thousand cycles the tests need.
   initial
   begin
      repeat (40000) @(posedge pclk);
      err_count++;
      tally_and_finish();
   end
   // Main sequence.
   initial
   begin
      {pclk, psel, penable, pwrite, obs} = '0;
      {paddr, pwdata, pstrb, amp_m, bg_m, ins_m, an_m, pu_m, dir_m} = '0;
      {err_count, checks} = '0;
      seed = 32'h1acb;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check_out();
      // Reset values, status and one unmapped hole.
      for (int i = 0; i < 8; i++)
      begin
         rd(8'h04 * i[7:0]);
      end
      check_out();
      $display("test reset values done");
      wr(BG_CTRL_OFS, 32'hffff_ffff, 4'hf);
      check_out();
      // Let the bandgap settle with the bus idle before it is chosen as amplifier input.
      repeat (16) @(posedge pclk);
      for (int i = 0; i < 64; i++)
      begin
         wr(AMP_CTRL_OFS, {24'h00_0000, i[5] | i[3], 2'b11, i[4:0]}, 4'hf);
         rd(AMP_CTRL_OFS);
         check_out();
      end
      $display("test amplifier and reference done");
      for (int i = 0; i < 256; i++)
      begin
         wr(INSEL_OFS, {$random(seed)} & 32'hffff_ff00 | i, 4'hf);
         // Status mirrors the registered switches, so read it once they have moved.
         check_out();
         rd(STATUS_OFS);
      end
      $display("test input routing done");
      for (int i = 0; i < 24; i++)
      begin
         wr(PIN_AN_OFS + 8'h04 * (i % 3), $random(seed), 4'($random(seed)));
         rd(PIN_AN_OFS + 8'h04 * (i % 3));
         check_out();
      end
      wr(8'h1c, 32'hffff_ffff, 4'hf);
      rd(8'h40);
      check_out();
      $display("test pins and unmapped done");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      {amp_m, bg_m, ins_m, an_m, pu_m, dir_m} = '0;
      @(posedge pclk);
      check_out();
      rd(PIN_AN_OFS);
      check_out();
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
